//--- slp_line.sv
// slp_line: indexed line parameters, modem status and fifo status reports
//
// Behaviour
// - tx rate code bits 15:12, reset 1101
// - rx rate code bits 11:8, reset 1101
// - rate codes map to sixteen ascending rates
// - bit 7 picks long stop length
// - bit 6 even parity, else odd
// - bit 5 enables parity add and check
// - bits 4:3 data bits, reset eight
// - diagnostic code 01 requests status report
// - filter bit cleared, reachable only at index zero
// - flow characters are octal 21 and 23
// - status upper byte holds modem inputs
// - status bit 15 shows dsr
// - status bit 13 shows ring indicator
// - status bit 12 shows carrier detect
// - status bit 11 shows cts
// - modem change pushes entry flagged 111
// - entry bit 0 tells modem from diagnostic
// - low four control bits pick the channel
// - modem change reports only on modem link channels
`timescale 1ns/10ps
`default_nettype none
module slp_line #(
  parameter int NUM_CH = slp_pkg::NUM_CH,
  parameter logic [6:0] REQUEST_A_INFO = 7'h00 // status payload, arbitrary
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic master_reset,
  input wire logic [3:0] channel_index,
  input wire logic lp_wr,
  input wire logic [15:0] lp_wdata,
  output logic [15:0] lp_rdata,
  output logic [15:0] stat_rdata,
  input wire logic [NUM_CH-1:0] dsr,
  input wire logic [NUM_CH-1:0] ri,
  input wire logic [NUM_CH-1:0] dcd,
  input wire logic [NUM_CH-1:0] cts,
  input wire logic [NUM_CH-1:0] link_type,
  input wire logic [NUM_CH-1:0] xoff_ctrl,
  input wire logic rx_valid,
  input wire logic [3:0] rx_line,
  input wire logic [7:0] rx_char,
  output logic rx_keep,
  output logic ent_valid,
  output slp_pkg::slp_entry_t ent,
  input wire logic ent_ready,
  output logic [NUM_CH-1:0] stop_long,
  output logic [NUM_CH-1:0] even_par,
  output logic [NUM_CH-1:0] parity_on,
  output logic [NUM_CH*2-1:0] data_bits_sel,
  output logic [NUM_CH*32-1:0] tx_bit_cycles,
  output logic [NUM_CH*32-1:0] rx_bit_cycles
);
  initial begin
    if (NUM_CH < 1 || NUM_CH > 8) $error("slp_line: channel count 1..8");
  end

  logic init_n;
  assign init_n = rst_b && !master_reset;

  // per channel settings: live copies for outputs, plus the store
  slp_pkg::slp_line_t cfg_q [NUM_CH];
  slp_pkg::slp_line_t cfg_d [NUM_CH];
  slp_pkg::slp_line_t wr_cfg, rd_cfg;
  logic [1:0] request_a_q, request_a_d;
  logic flow_char_filter_q, flow_char_filter_d;
  logic [2:0] ch;
  logic ch_ok;
  logic request_a_take;

  assign ch = channel_index[2:0];
  assign ch_ok = 32'(channel_index) < NUM_CH;

  // split the written word into fields
  always_comb begin
    wr_cfg.tx_rate = lp_wdata[slp_pkg::TX_RATE_LSB +: 4];
    wr_cfg.rx_rate = lp_wdata[slp_pkg::RX_RATE_LSB +: 4];
    wr_cfg.stop_long = lp_wdata[slp_pkg::STOP_BIT];
    wr_cfg.even = lp_wdata[slp_pkg::EVEN_BIT];
    wr_cfg.parity_on = lp_wdata[slp_pkg::PARITY_ON_BIT];
    wr_cfg.data_bits_sel = lp_wdata[slp_pkg::DATA_BITS_LSB +: 2];
  end

  slp_mem #(.DEPTH(NUM_CH), .AW(3)) u_mem (
    .ref_clk(ref_clk),
    .rst_b(init_n),
    .wr_en(lp_wr && ch_ok),
    .wr_addr(ch),
    .wr_data(wr_cfg),
    .rd_addr(ch),
    .rd_data(rd_cfg)
  );

  // shadow copies feed the per-channel line logic in parallel
  for (genvar i = 0; i < NUM_CH; i++) begin : g_cfg
    always_comb begin
      cfg_d[i] = cfg_q[i];
      if (lp_wr && ch_ok && ch == 3'(i)) begin
        cfg_d[i] = wr_cfg;
      end
    end
    always_ff @(posedge ref_clk) begin
      if (!init_n) begin
        cfg_q[i] <= '{tx_rate: slp_pkg::RATE_RST, rx_rate: slp_pkg::RATE_RST,
          stop_long: 1'b0, even: 1'b0, parity_on: 1'b0,
          data_bits_sel: slp_pkg::DATA_BITS_RST};
      end else begin
        cfg_q[i] <= cfg_d[i];
      end
    end
    // bit time in clocks, rounded down; low rates stay well in range
    always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
        tx_bit_cycles[i*32 +: 32] <= '0;
        rx_bit_cycles[i*32 +: 32] <= '0;
        stop_long[i] <= 1'b0;
        even_par[i] <= 1'b0;
        parity_on[i] <= 1'b0;
        data_bits_sel[i*2 +: 2] <= 2'h0;
      end else begin
        tx_bit_cycles[i*32 +: 32] <= 32'(slp_pkg::CLK_HZ * 10 /
          slp_pkg::RATE_X10[cfg_q[i].tx_rate]);
        rx_bit_cycles[i*32 +: 32] <= 32'(slp_pkg::CLK_HZ * 10 /
          slp_pkg::RATE_X10[cfg_q[i].rx_rate]);
        stop_long[i] <= cfg_q[i].stop_long;
        even_par[i] <= cfg_q[i].even & cfg_q[i].parity_on;
        parity_on[i] <= cfg_q[i].parity_on;
        data_bits_sel[i*2 +: 2] <= cfg_q[i].data_bits_sel;
      end
    end
  end

  // global fields; a host write in the cycle of the clear wins over it
  always_comb begin
    request_a_d = request_a_q;
    flow_char_filter_d = flow_char_filter_q;
    if (request_a_take) begin
      request_a_d = slp_pkg::REQUEST_A_NORMAL;
    end
    if (lp_wr) begin
      request_a_d = lp_wdata[slp_pkg::REQUEST_A_LSB +: 2];
      if (channel_index == 4'h0) begin
        flow_char_filter_d = lp_wdata[slp_pkg::FILTER_BIT];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!init_n) begin
      request_a_q <= slp_pkg::REQUEST_A_NORMAL;
      flow_char_filter_q <= 1'b0;
    end else begin
      request_a_q <= request_a_d;
      flow_char_filter_q <= flow_char_filter_d;
    end
  end

  // readback: low bit shows filter only at index zero
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      lp_rdata <= 16'h0000;
    end else begin
      lp_rdata <= {rd_cfg.tx_rate, rd_cfg.rx_rate, rd_cfg.stop_long,
        rd_cfg.even, rd_cfg.parity_on, rd_cfg.data_bits_sel, request_a_q,
        flow_char_filter_q & (channel_index == 4'h0)};
    end
  end

  // received flow characters dropped when both bits set
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      rx_keep <= 1'b1;
    end else begin
      rx_keep <= !(rx_valid && flow_char_filter_q && xoff_ctrl[rx_line[2:0]]
        && (rx_char == slp_pkg::XON_CHAR
        || rx_char == slp_pkg::XOFF_CHAR));
    end
  end

  // modem status per channel: inputs already synchronous
  logic [7:0] mstat [NUM_CH];
  logic [7:0] prev_q [NUM_CH];
  logic [NUM_CH-1:0] pend_q, pend_d;
  for (genvar i = 0; i < NUM_CH; i++) begin : g_mod
    always_comb begin
      mstat[i] = 8'h00;
      mstat[i][slp_pkg::DSR_POS] = dsr[i];
      mstat[i][slp_pkg::RI_POS] = ri[i];
      mstat[i][slp_pkg::DCD_POS] = dcd[i];
      mstat[i][slp_pkg::CTS_POS] = cts[i];
    end
    always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
        prev_q[i] <= 8'h00;
      end else begin
        prev_q[i] <= mstat[i];
      end
    end
  end

  // pending flags: a new change wins over the clear by a push
  logic [2:0] sel;
  logic sel_ok;
  always_comb begin
    sel = 3'h0;
    sel_ok = 1'b0;
    for (int k = NUM_CH - 1; k >= 0; k--) begin
      if (pend_q[k]) begin
        sel = 3'(k);
        sel_ok = 1'b1;
      end
    end
  end
  assign request_a_take = (request_a_q == slp_pkg::REQUEST_A_REPORT) && !sel_ok &&
    (!ent_valid || ent_ready);

  always_comb begin
    pend_d = pend_q;
    if (sel_ok && (!ent_valid || ent_ready)) begin
      pend_d[sel] = 1'b0;
    end
    for (int k = 0; k < NUM_CH; k++) begin
      if (mstat[k] != prev_q[k] && link_type[k]) begin
        pend_d[k] = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!init_n) begin
      pend_q <= '0;
    end else begin
      pend_q <= pend_d;
    end
  end

  // fifo entry output register
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      ent_valid <= 1'b0;
      ent <= '0;
    end else if (!ent_valid || ent_ready) begin
      ent_valid <= sel_ok || request_a_take;
      if (sel_ok) begin
        ent <= '{flags: slp_pkg::SPECIAL_FLAGS, line: {1'b0, sel},
          data: {mstat[sel][7:1], slp_pkg::MARK_MODEM}};
      end else begin
        ent <= '{flags: slp_pkg::SPECIAL_FLAGS, line: channel_index,
          data: {REQUEST_A_INFO, slp_pkg::MARK_REQUEST_A}};
      end
    end
  end

  // status register of the selected channel, low byte zero
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      stat_rdata <= 16'h0000;
    end else begin
      stat_rdata <= {ch_ok ? mstat[ch] : 8'h00, 8'h00};
    end
  end

  // checks
  dsr_stat_a: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    (channel_index == 4'h3) |=> stat_rdata[15] == $past(dsr[3]))
    else $error("dsr not shown");
  stat_low_a: assert property (@(posedge ref_clk)
    disable iff (!rst_b) stat_rdata[7:0] == 8'h00)
    else $error("status low byte not zero");
  ent_flag_a: assert property (@(posedge ref_clk)
    disable iff (!rst_b) ent_valid |-> ent.flags == slp_pkg::SPECIAL_FLAGS)
    else $error("entry flags wrong");
  no_link_a: assert property (@(posedge ref_clk)
    disable iff (!init_n) (!link_type[2] && !pend_q[2]) |=> !pend_q[2])
    else $error("report on data-only line");
  change_a: assert property (@(posedge ref_clk)
    disable iff (!init_n)
    (link_type[3] && dsr[3] != $past(dsr[3])) |=> pend_q[3])
    else $error("change not flagged");
  filt_a: assert property (@(posedge ref_clk)
    disable iff (!rst_b) (rx_valid && !flow_char_filter_q) |=> rx_keep)
    else $error("chars dropped without filter");
  rst_rate_a: assert property (@(posedge ref_clk)
    !init_n |=> cfg_q[0].tx_rate == slp_pkg::RATE_RST)
    else $error("tx rate reset wrong");
  filt_idx_a: assert property (@(posedge ref_clk)
    disable iff (!init_n)
    (lp_wr && channel_index != 4'h0) |=> $stable(flow_char_filter_q))
    else $error("filter bit written off index zero");
  request_a_clr_a: assert property (@(posedge ref_clk)
    disable iff (!init_n)
    (request_a_take && !lp_wr) |=> request_a_q == slp_pkg::REQUEST_A_NORMAL)
    else $error("status request not cleared");
  cv_modem_c: cover property (@(posedge ref_clk)
    ent_valid && ent_ready && ent.data[0] == 1'b0);
  cv_request_a_c: cover property (@(posedge ref_clk)
    ent_valid && ent_ready && ent.data[0] == 1'b1);
  cv_drop_c: cover property (@(posedge ref_clk) !rx_keep);
endmodule // slp_line
`default_nettype wire

//--- slp_mem.sv
// slp_mem: small per-channel settings store with registered read port
`timescale 1ns/10ps
`default_nettype none
module slp_mem #(
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire slp_pkg::slp_line_t wr_data,
  input wire logic [AW-1:0] rd_addr,
  output slp_pkg::slp_line_t rd_data
);
  slp_pkg::slp_line_t mem_q [DEPTH];
  slp_pkg::slp_line_t mem_d [DEPTH];
  slp_pkg::slp_line_t rd_q, rd_d;
  slp_pkg::slp_line_t rst_val;

  initial begin
    if (DEPTH > (1 << AW)) $error("slp_mem: depth beyond address range");
  end

  // reset values of a channel
  always_comb begin
    rst_val = '0;
    rst_val.tx_rate = slp_pkg::RATE_RST;
    rst_val.rx_rate = slp_pkg::RATE_RST;
    rst_val.data_bits_sel = slp_pkg::DATA_BITS_RST;
  end

  // one entry per channel
  for (genvar i = 0; i < DEPTH; i++) begin : g_ent
    always_comb begin
      mem_d[i] = mem_q[i];
      if (wr_en && wr_addr == AW'(i)) begin
        mem_d[i] = wr_data;
      end
    end
    always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
        mem_q[i] <= rst_val;
      end else begin
        mem_q[i] <= mem_d[i];
      end
    end
  end

  always_comb begin
    rd_d = mem_q[rd_addr];
  end

  // registered read port
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      rd_q <= '0;
    end else begin
      rd_q <= rd_d;
    end
  end
  assign rd_data = rd_q;
endmodule // slp_mem
`default_nettype wire

//--- slp_modem_model.sv
// slp_modem_model: modem lines and receive fifo sink at the far side
`timescale 1ns/10ps
`default_nettype none
module slp_modem_model (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic flip,
  input wire logic [2:0] flip_ch,
  input wire logic [1:0] flip_sig,
  input wire logic slow,
  input wire logic ent_valid,
  output logic ent_ready,
  output logic [7:0] dsr,
  output logic [7:0] ri,
  output logic [7:0] dcd,
  output logic [7:0] cts
);
  logic [1:0] wait_q;
  // a modem line moves only on command, one line per edge
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      {dsr, ri, dcd, cts} <= '0;
    end else if (flip) begin
      case (flip_sig)
        2'h0: dsr[flip_ch] <= ~dsr[flip_ch];
        2'h1: ri[flip_ch] <= ~ri[flip_ch];
        2'h2: dcd[flip_ch] <= ~dcd[flip_ch];
        default: cts[flip_ch] <= ~cts[flip_ch];
      endcase
    end
  end
  // sink takes one entry per ready pulse; slow mode stalls so entries
  // must stand
  always_ff @(posedge ref_clk) begin
    if (!rst_b || !ent_valid || ent_ready) begin
      wait_q <= 2'h0;
      ent_ready <= 1'b0;
    end else begin
      wait_q <= wait_q + 2'h1;
      ent_ready <= !slow || wait_q == 2'h2;
    end
  end
endmodule // slp_modem_model
`default_nettype wire

//--- slp_pkg.sv
// package: register layout, reset values and entry formats for line params
package slp_pkg;
  localparam int unsigned NUM_CH = 8;
  // line parameter field positions
  localparam int unsigned TX_RATE_LSB = 12;
  localparam int unsigned RX_RATE_LSB = 8;
  localparam int unsigned STOP_BIT = 7;
  localparam int unsigned EVEN_BIT = 6;
  localparam int unsigned PARITY_ON_BIT = 5;
  localparam int unsigned DATA_BITS_LSB = 3;
  localparam int unsigned REQUEST_A_LSB = 1;
  localparam int unsigned FILTER_BIT = 0;
  // reset values
  localparam logic [3:0] RATE_RST = 4'hd;
  localparam logic [1:0] DATA_BITS_RST = 2'h3;
  localparam logic [1:0] REQUEST_A_NORMAL = 2'h0;
  localparam logic [1:0] REQUEST_A_REPORT = 2'h1;
  // flow control characters (octal 21 and 23)
  localparam logic [7:0] XON_CHAR = 8'h11;
  localparam logic [7:0] XOFF_CHAR = 8'h13;
  // fifo entry flags
  localparam logic [2:0] SPECIAL_FLAGS = 3'h7;
  localparam logic MARK_MODEM = 1'b0;
  localparam logic MARK_REQUEST_A = 1'b1;
  // modem status bit positions inside the upper byte
  localparam int unsigned DSR_POS = 7;
  localparam int unsigned RI_POS = 5;
  localparam int unsigned DCD_POS = 4;
  localparam int unsigned CTS_POS = 3;
  // bit rate of each rate code, in tenths of a bit per second
  localparam int unsigned RATE_X10 [16] = '{500, 750, 1100, 1345, 1500,
    3000, 6000, 12000, 18000, 20000, 24000, 48000, 72000, 96000, 192000,
    384000};
  localparam int unsigned CLK_HZ = 50000000;

  // one channel's line settings
  typedef struct packed {
    logic [3:0] tx_rate;
    logic [3:0] rx_rate;
    logic stop_long;
    logic even;
    logic parity_on;
    logic [1:0] data_bits_sel;
  } slp_line_t;

  // one receive fifo entry
  typedef struct packed {
    logic [2:0] flags;
    logic [3:0] line;
    logic [7:0] data;
  } slp_entry_t;
endpackage

//--- tb_top.sv
// tb_top: self-checking bench for the line parameter and status block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic master_reset = 1'b0;
  logic [3:0] channel_index = 4'h0;
  logic lp_wr = 1'b0;
  logic [15:0] lp_wdata = 16'h0000;
  logic [7:0] link_type = 8'h00;
  logic [7:0] xoff_ctrl = 8'h00;
  logic rx_valid = 1'b0;
  logic [3:0] rx_line = 4'h0;
  logic [7:0] rx_char = 8'h00;
  logic flip = 1'b0;
  logic [2:0] flip_ch = 3'h0;
  logic [1:0] flip_sig = 2'h0;
  logic slow = 1'b0;
  logic [15:0] lp_rdata, stat_rdata, s;
  logic rx_keep, ent_valid, ent_ready;
  slp_pkg::slp_entry_t ent;
  logic [7:0] dsr, ri, dcd, cts, stop_long, even_par, parity_on;
  logic [15:0] data_bits_sel;
  logic [255:0] tx_bit_cycles, rx_bit_cycles;
  int n_errors = 0;
  int n_checks = 0;
  int cycles = 0;

  slp_line u_dut (.ref_clk(ref_clk), .rst_b(rst_b),
    .master_reset(master_reset), .channel_index(channel_index),
    .lp_wr(lp_wr), .lp_wdata(lp_wdata), .lp_rdata(lp_rdata),
    .stat_rdata(stat_rdata), .dsr(dsr), .ri(ri), .dcd(dcd), .cts(cts),
    .link_type(link_type), .xoff_ctrl(xoff_ctrl), .rx_valid(rx_valid),
    .rx_line(rx_line), .rx_char(rx_char), .rx_keep(rx_keep),
    .ent_valid(ent_valid), .ent(ent), .ent_ready(ent_ready),
    .stop_long(stop_long), .even_par(even_par), .parity_on(parity_on),
    .data_bits_sel(data_bits_sel), .tx_bit_cycles(tx_bit_cycles),
    .rx_bit_cycles(rx_bit_cycles));
  slp_modem_model u_modem (.ref_clk(ref_clk), .rst_b(rst_b), .flip(flip),
    .flip_ch(flip_ch), .flip_sig(flip_sig), .slow(slow),
    .ent_valid(ent_valid), .ent_ready(ent_ready), .dsr(dsr), .ri(ri),
    .dcd(dcd), .cts(cts));

  always #10 ref_clk = ~ref_clk;

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ceiling well above the few hundred cycles the tests need
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      stop_test();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
      input string what);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s %h not %h", $time, what, seen, exp);
    end
  endtask
  // caller lowers lp_wr, so writes may follow each other without gaps
  task automatic lp_write(input logic [3:0] ch, input logic [15:0] v);
    channel_index <= ch;
    lp_wr <= 1'b1;
    lp_wdata <= v;
    @(posedge ref_clk);
  endtask
  task automatic lp_read(input logic [3:0] ch, input logic [15:0] exp);
    channel_index <= ch;
    lp_wr <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1 check(lp_rdata, exp, "line parameters");
    @(posedge ref_clk);
  endtask
  function automatic logic [15:0] stat_of(input int c);
    return {dsr[c], 1'b0, ri[c], dcd[c], cts[c], 11'h000};
  endfunction
  task automatic stat_read(input logic [3:0] ch);
    channel_index <= ch;
    repeat (3) @(posedge ref_clk);
    #1 check(stat_rdata, ch < 8 ? stat_of(ch) : 16'h0000, "status");
    @(posedge ref_clk);
  endtask
  task automatic modem_flip(input logic [2:0] ch, input logic [1:0] sig);
    flip <= 1'b1;
    flip_ch <= ch;
    flip_sig <= sig;
    @(posedge ref_clk);
    flip <= 1'b0;
    @(posedge ref_clk);
  endtask
  // entry must stand unchanged until the sink takes it
  task automatic get_entry(input logic [3:0] line, input logic [7:0] d);
    int i;
    for (i = 0; i < 40 && ent_valid !== 1'b1; i++) @(negedge ref_clk);
    check({ent_valid, ent}, {1'b1, slp_pkg::SPECIAL_FLAGS, line, d}, "entry");
    for (i = 0; i < 10 && ent_ready !== 1'b1; i++) @(negedge ref_clk);
    check({ent_valid, ent}, {1'b1, slp_pkg::SPECIAL_FLAGS, line, d}, "held");
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic rx_try(input logic [3:0] line, input logic [7:0] c,
      input logic keep);
    rx_valid <= 1'b1;
    rx_line <= line;
    rx_char <= c;
    @(posedge ref_clk);
    rx_valid <= 1'b0;
    #1 check(rx_keep, keep, "keep flag");
    @(posedge ref_clk);
  endtask
  function automatic logic [15:0] cfg(input int c);
    return {4'(c), 4'(c + 8), c[0], c[1], c[2], c[1:0], 3'h0};
  endfunction
  function automatic logic [31:0] rate_cycles(input int k);
    return 32'(slp_pkg::CLK_HZ * 10 / slp_pkg::RATE_X10[k]);
  endfunction

  initial begin
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    lp_read(4'h0, 16'hdd18);
    check(data_bits_sel[1:0], slp_pkg::DATA_BITS_RST, "bits");
    $display("test done: reset values");
    // every rate code on both directions, counts reckoned from bit rates
    for (int k = 0; k < 16; k++) begin
      lp_write(4'h0, {k[3:0], 4'(15 - k), 8'h18});
      lp_read(4'h0, {k[3:0], 4'(15 - k), 8'h18});
      check(tx_bit_cycles[31:0], rate_cycles(k), "tx time");
      check(rx_bit_cycles[31:0], rate_cycles(15 - k), "rx time");
      if (k == 13) check(tx_bit_cycles[31:0], 32'h1458, "9600 tx");
      if (k == 2) check(rx_bit_cycles[31:0], 32'h1458, "9600 rx");
    end
    $display("test done: rate codes");
    for (int c = 1; c < 8; c++) lp_write(c[3:0], cfg(c));
    for (int c = 1; c < 8; c++) begin
      lp_read(c[3:0], cfg(c));
      check({stop_long[c], parity_on[c], even_par[c],
        data_bits_sel[2*c+:2]}, {c[0], c[2], c[1] & c[2], c[1:0]},
        "line outputs");
    end
    lp_write(4'h1, cfg(1) | 16'h0001);
    lp_read(4'h0, 16'hf018);
    lp_write(4'h0, 16'hf019);
    lp_write(4'h8, 16'h0000);
    lp_read(4'h0, 16'hf019);
    lp_read(4'h1, cfg(1));
    stat_read(4'h8);
    $display("test done: channel settings");
    xoff_ctrl <= 8'h02;
    rx_try(4'h1, slp_pkg::XON_CHAR, 1'b0);
    rx_try(4'h1, slp_pkg::XOFF_CHAR, 1'b0);
    rx_try(4'h1, 8'h12, 1'b1);
    rx_try(4'h2, slp_pkg::XON_CHAR, 1'b1);
    lp_write(4'h0, 16'hf018);
    lp_read(4'h0, 16'hf018);
    rx_try(4'h1, slp_pkg::XOFF_CHAR, 1'b1);
    $display("test done: flow filter");
    // sink stalls, so a wrong report would still stand at the check
    slow <= 1'b1;
    for (int g = 0; g < 4; g++) begin
      modem_flip(3'h2, g[1:0]);
      stat_read(4'h2);
      check(ent_valid, 1'b0, "no report");
    end
    link_type <= 8'h08;
    for (int g = 0; g < 4; g++) begin
      modem_flip(3'h3, g[1:0]);
      s = stat_of(3);
      get_entry(4'h3, {s[15:9], slp_pkg::MARK_MODEM});
      stat_read(4'h3);
    end
    $display("test done: modem reports");
    slow <= 1'b0;
    lp_write(4'h5, cfg(5) | 16'h0002);
    lp_wr <= 1'b0;
    get_entry(4'h5, {7'h00, slp_pkg::MARK_REQUEST_A});
    lp_read(4'h5, cfg(5));
    $display("test done: status request");
    lp_write(4'h0, 16'h0001);
    master_reset <= 1'b1;
    lp_wr <= 1'b0;
    @(posedge ref_clk);
    master_reset <= 1'b0;
    lp_read(4'h5, 16'hdd18);
    lp_read(4'h0, 16'hdd18);
    $display("test done: master reset");
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
